/* File: src/atfd_task_file.sv */
`timescale 1ns/10ps
`include "atfd_params.svh"
// How it works
// - memory mode, A10 low: A3-A0 pick registers, duplicates at 8,9,d; e alt status/control, f drive address
// - memory mode, A10 high: any address is data, A0 picks even/odd byte
// - both enables: 16-bit data, registers on low lane; ce1 only: low lane; ce2 only: odd byte high lane
// - shared offsets read one register, write another; drive address write ignored
// - contiguous i/o mode decodes sixteen offsets on A3-A0 like memory mode
// - primary i/o decodes full A9-A0 at 1f0-1f7, 3f6, 3f7
// - secondary i/o decodes full A9-A0 at 170-177, 376, 377
// - ide, ce1 only: command block by A2-A0, offset 0 is 16-bit data
// - ide, ce2 only: 6 alt status/control, 7 drive address, else bus undriven
// - data register moves sector-buffer words in runs of 8 or 16 bit accesses
// - error register read-only: bit7 bad block, bit6 uncorrectable, 5,3,1 zero
// - error bit4 id missing, bit2 aborted command, bit0 general error
// - write-only 8-bit feature register holds command parameters
// - sector count written by host, updated by core at completion
// - sector number written by host, updated by core at completion
// - cylinder low written by host, updated by core at completion
// - cylinder high written by host, updated by core at completion
// - drive/head written by host, updated by core at completion
// - drive/head bits 7,5 read one, bit6 lba, bit4 unit, 3-0 head
// - command executes only if unit bit equals socket copy drive number
// - status read clears pending interrupt; alternate status read does not
// - control bit2 holds soft reset, bit1 masks interrupt output
module atfd_task_file #(
    parameter int BUF_AW = 9
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // configuration
    input  wire atfd_pkg::atfd_mode_t mode,
    input  wire logic              socket_drive,
    // host pins, active-low strobes sampled synchronously
    input  wire logic [10:0]       host_addr,
    input  wire logic              host_ce1_n,
    input  wire logic              host_ce2_n,
    input  wire logic              host_reg_n,
    input  wire logic              host_oe_n,
    input  wire logic              host_we_n,
    input  wire logic              host_iord_n,
    input  wire logic              host_iowr_n,
    input  wire logic [15:0]       host_data_in,
    output logic      [15:0]       host_data_out,
    output logic      [1:0]        host_data_oe,
    output logic                   host_irq_n,
    // core side: status, errors, completion update
    input  wire logic [7:0]        core_status,
    input  wire logic [7:0]        core_error,
    input  wire logic              core_irq_set,
    input  wire logic              core_done,
    input  wire logic [7:0]        core_count,
    input  wire logic [7:0]        core_sect,
    input  wire logic [7:0]        core_cyllo,
    input  wire logic [7:0]        core_cylhi,
    input  wire logic [3:0]        core_head,
    output logic [7:0]             cmd_code,
    output logic                   cmd_valid,
    input  wire logic              cmd_ready,
    output logic                   soft_reset,
    output logic [7:0]             feature_r,
    output logic [7:0]             count_r,
    output logic [7:0]             sect_r,
    output logic [7:0]             cyllo_r,
    output logic [7:0]             cylhi_r,
    output logic [7:0]             drvhd_r,
    // sector buffer: byte address plus data
    output logic [BUF_AW-1:0]      buf_ptr_r,
    output logic                   buf_wr,
    output logic [15:0]            buf_wdata,
    output logic                   buf_wide,
    input  wire logic [15:0]       buf_rdata
);
    ////////////////////////////////////////////////////////////////////////////////
    // decode
    logic       rd_s, wr_s, acc, rd_q, wr_q, rd_edge, wr_edge;
    logic       lo_lane, hi_lane, wide, odd_byte;
    logic [3:0] off;
    atfd_pkg::atfd_sel_t sel;
    logic       io_mode;

    assign io_mode = (mode != atfd_pkg::ATFD_MODE_MEM);
    assign rd_s = io_mode ? ~host_iord_n : ~host_oe_n;
    assign wr_s = io_mode ? ~host_iowr_n : ~host_we_n;
    assign wide = ~host_ce1_n & ~host_ce2_n;
    assign lo_lane = ~host_ce1_n;
    assign hi_lane = ~host_ce2_n;

    always_comb begin
        sel = atfd_pkg::ATFD_SEL_NONE;
        off = host_addr[3:0];
        odd_byte = host_addr[0] | (host_ce1_n & ~host_ce2_n);
        case (mode)
            atfd_pkg::ATFD_MODE_MEM: begin
                if (host_reg_n) begin
                    if (host_addr[10]) begin
                        sel = atfd_pkg::ATFD_SEL_DATA;
                        off = `ATFD_OFF_DATA;
                    end else begin
                        sel = atfd_pkg::ATFD_SEL_REG;
                    end
                end
            end
            atfd_pkg::ATFD_MODE_IO16: begin
                if (!host_reg_n) begin
                    sel = atfd_pkg::ATFD_SEL_REG;
                end
            end
            atfd_pkg::ATFD_MODE_PRI, atfd_pkg::ATFD_MODE_SEC: begin
                if (!host_reg_n) begin
                    if ({host_addr[9:3], 3'h0} ==
                        ((mode == atfd_pkg::ATFD_MODE_PRI) ? `ATFD_PRI_CMD
                                                           : `ATFD_SEC_CMD)) begin
                        sel = atfd_pkg::ATFD_SEL_REG;
                        off = {1'b0, host_addr[2:0]};
                    end else if ({host_addr[9:1], 1'b0} ==
                        ((mode == atfd_pkg::ATFD_MODE_PRI) ? `ATFD_PRI_CTL
                                                           : `ATFD_SEC_CTL)) begin
                        sel = atfd_pkg::ATFD_SEL_REG;
                        off = {3'h7, host_addr[0]};
                    end
                end
            end
            atfd_pkg::ATFD_MODE_IDE: begin
                odd_byte = 1'b0;
                if (!host_ce1_n && host_ce2_n) begin
                    sel = atfd_pkg::ATFD_SEL_REG;
                    off = {1'b0, host_addr[2:0]};
                end else if (host_ce1_n && !host_ce2_n && host_addr[2:1] == 2'h3) begin
                    sel = atfd_pkg::ATFD_SEL_REG;
                    off = {3'h7, host_addr[0]};
                end
            end
            default: sel = atfd_pkg::ATFD_SEL_NONE;
        endcase
        // byte-mode pairs: ce2-only reaches odd member of even/odd pair
        if (sel == atfd_pkg::ATFD_SEL_REG && mode != atfd_pkg::ATFD_MODE_IDE
            && host_ce1_n && !host_ce2_n) begin
            off = {off[3:1], 1'b1};
        end
        if (sel == atfd_pkg::ATFD_SEL_REG && (off == `ATFD_OFF_DATA
            || off == `ATFD_OFF_DUPE || off == `ATFD_OFF_DUPO)) begin
            sel = atfd_pkg::ATFD_SEL_DATA;
            if (off == `ATFD_OFF_DUPO) odd_byte = 1'b1;
            if (off == `ATFD_OFF_DUPE) odd_byte = 1'b0;
        end
        if (sel == atfd_pkg::ATFD_SEL_REG && off == `ATFD_OFF_DUPERR) begin
            off = `ATFD_OFF_ERR;
        end
        if (sel == atfd_pkg::ATFD_SEL_REG && off == `ATFD_OFF_ALTST) begin
            sel = atfd_pkg::ATFD_SEL_CTL;
        end
        if (sel == atfd_pkg::ATFD_SEL_REG && off == `ATFD_OFF_DRVADR) begin
            sel = atfd_pkg::ATFD_SEL_ADR;
        end
        // both enables low in ide is unused
        if (mode == atfd_pkg::ATFD_MODE_IDE && wide) begin
            sel = atfd_pkg::ATFD_SEL_NONE;
        end
        if (host_ce1_n && host_ce2_n) begin
            sel = atfd_pkg::ATFD_SEL_NONE;
        end
    end

    assign acc = (sel != atfd_pkg::ATFD_SEL_NONE);
    // strobes act once, on their leading edge, so a long strobe is one access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else if (clk_en) begin
            rd_q <= rd_s;
            wr_q <= wr_s;
        end
    end
    assign rd_edge = clk_en & rd_s & ~rd_q & acc;
    assign wr_edge = clk_en & wr_s & ~wr_q & acc;

    logic [7:0] wbyte;
    // ide control block sits on the low lane even though only ce2 is low
    assign wbyte = (host_ce1_n && !host_ce2_n && mode != atfd_pkg::ATFD_MODE_IDE)
                 ? host_data_in[15:8] : host_data_in[7:0];

    ////////////////////////////////////////////////////////////////////////////////
    // task-file registers
    logic ctl_soft_reset_bit_r, ctl_imask_r;
    logic wreg;
    assign wreg = wr_edge && sel == atfd_pkg::ATFD_SEL_REG;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            feature_r <= 8'h00;
            count_r   <= `ATFD_COUNT_RST;
            sect_r    <= 8'h01;
            cyllo_r   <= 8'h00;
            cylhi_r   <= 8'h00;
            drvhd_r   <= `ATFD_DH_RST;
        end else if (clk_en) begin
            if (core_done) begin
                count_r <= core_count;
                sect_r  <= core_sect;
                cyllo_r <= core_cyllo;
                cylhi_r <= core_cylhi;
                drvhd_r <= {drvhd_r[7:4], core_head};
            end else if (wreg) begin
                case (off)
                    `ATFD_OFF_ERR:   feature_r <= wbyte;
                    `ATFD_OFF_COUNT: count_r <= wbyte;
                    `ATFD_OFF_SECT:  sect_r <= wbyte;
                    `ATFD_OFF_CYLLO: cyllo_r <= wbyte;
                    `ATFD_OFF_CYLHI: cylhi_r <= wbyte;
                    `ATFD_OFF_DRVHD: drvhd_r <= wbyte | `ATFD_DH_ONES;
                    default: ;
                endcase
            end
        end
    end

    // device control; drive-address writes fall through to nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_soft_reset_bit_r  <= 1'b0;
            ctl_imask_r <= 1'b0;
        end else if (clk_en && wr_edge && sel == atfd_pkg::ATFD_SEL_CTL) begin
            ctl_soft_reset_bit_r  <= wbyte[`ATFD_DC_SOFT_RESET_BIT];
            ctl_imask_r <= wbyte[`ATFD_DC_IMASK];
        end
    end
    assign soft_reset = ctl_soft_reset_bit_r;

    ////////////////////////////////////////////////////////////////////////////////
    // command hand-off through a two-entry buffer
    logic [7:0] cq_d [2];
    logic [1:0] cq_cnt_r;
    logic       cq_wp_r, cq_rp_r, cq_push, cq_pop;
    // a command for the other unit is dropped here, core never sees it
    assign cq_push = wreg && off == `ATFD_OFF_STAT
                     && drvhd_r[`ATFD_DH_UNIT] == socket_drive
                     && cq_cnt_r != 2'h2 && !ctl_soft_reset_bit_r;
    assign cq_pop = clk_en && cmd_valid && cmd_ready;
    assign cmd_valid = (cq_cnt_r != 2'h0);
    assign cmd_code = cq_d[cq_rp_r];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cq_cnt_r <= 2'h0;
            cq_wp_r  <= 1'b0;
            cq_rp_r  <= 1'b0;
            cq_d[0]  <= 8'h00;
            cq_d[1]  <= 8'h00;
        end else if (clk_en) begin
            if (cq_push) begin
                cq_d[cq_wp_r] <= wbyte;
                cq_wp_r <= ~cq_wp_r;
            end
            if (cq_pop) cq_rp_r <= ~cq_rp_r;
            cq_cnt_r <= cq_cnt_r + {1'b0, cq_push} - {1'b0, cq_pop};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt pending
    logic irq_pend_r, stat_rd;
    assign stat_rd = rd_edge && sel == atfd_pkg::ATFD_SEL_REG && off == `ATFD_OFF_STAT;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pend_r <= 1'b0;
        end else if (clk_en) begin
            if (core_irq_set) irq_pend_r <= 1'b1;                    // set wins over clear
            else if (stat_rd || ctl_soft_reset_bit_r) irq_pend_r <= 1'b0;
        end
    end
    assign host_irq_n = ~(irq_pend_r & ~ctl_imask_r);

    ////////////////////////////////////////////////////////////////////////////////
    // sector buffer pointer
    logic dacc;
    assign dacc = (rd_edge | wr_edge) && sel == atfd_pkg::ATFD_SEL_DATA;
    assign buf_wide = wide && mode != atfd_pkg::ATFD_MODE_IDE ? 1'b1
                    : (mode == atfd_pkg::ATFD_MODE_IDE);
    assign buf_wr = dacc & wr_s;
    assign buf_wdata = buf_wide ? host_data_in : {wbyte, wbyte};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_ptr_r <= '0;
        end else if (clk_en && (ctl_soft_reset_bit_r || core_done)) begin
            buf_ptr_r <= '0;
        end else if (dacc) begin
            buf_ptr_r <= buf_ptr_r + (buf_wide ? BUF_AW'(2) : BUF_AW'(1));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data, registered
    logic [7:0] rbyte;
    always_comb begin
        case (off)
            `ATFD_OFF_ERR:   rbyte = core_error & ~`ATFD_ERR_ZERO;
            `ATFD_OFF_COUNT: rbyte = count_r;
            `ATFD_OFF_SECT:  rbyte = sect_r;
            `ATFD_OFF_CYLLO: rbyte = cyllo_r;
            `ATFD_OFF_CYLHI: rbyte = cylhi_r;
            `ATFD_OFF_DRVHD: rbyte = drvhd_r | `ATFD_DH_ONES;
            `ATFD_OFF_STAT:  rbyte = core_status;
            `ATFD_OFF_ALTST: rbyte = core_status;
            `ATFD_OFF_DRVADR: rbyte = {2'h3, ~drvhd_r[3:0], ~drvhd_r[`ATFD_DH_UNIT],
                                       drvhd_r[`ATFD_DH_UNIT]};
            default:         rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_data_out <= 16'h0000;
            host_data_oe  <= 2'h0;
        end else if (clk_en) begin
            if (rd_s && acc) begin
                if (sel == atfd_pkg::ATFD_SEL_DATA) begin
                    // data is taken once: the pointer moves on at the access edge
                    if (rd_edge) begin
                        if (buf_wide) host_data_out <= buf_rdata;
                        else if (odd_byte) host_data_out <= {buf_rdata[15:8], buf_rdata[15:8]};
                        else host_data_out <= {buf_rdata[7:0], buf_rdata[7:0]};
                    end
                end else begin
                    host_data_out <= {rbyte, rbyte};
                end
                host_data_oe <= (sel == atfd_pkg::ATFD_SEL_DATA && buf_wide) ? 2'h3
                              : (mode == atfd_pkg::ATFD_MODE_IDE) ? 2'h1
                              : {hi_lane & ~lo_lane, lo_lane};
            end else begin
                host_data_oe <= 2'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    chk_irq_clear: assert property (@(posedge clk) disable iff (!rst_n)
        stat_rd && !core_irq_set |=> !irq_pend_r)
        else $error("status read left interrupt pending");
    chk_irq_mask: assert property (@(posedge clk) disable iff (!rst_n)
        ctl_imask_r |-> host_irq_n)
        else $error("masked interrupt reached output");
    chk_dh_ones: assert property (@(posedge clk) disable iff (!rst_n)
        drvhd_r[7] && drvhd_r[5])
        else $error("drive head fixed bits lost");
    chk_ptr_step: assert property (@(posedge clk) disable iff (!rst_n)
        dacc && !ctl_soft_reset_bit_r && !core_done && buf_wide |=>
        buf_ptr_r == $past(buf_ptr_r) + BUF_AW'(2))
        else $error("pointer did not advance by two");
    chk_unit_gate: assert property (@(posedge clk) disable iff (!rst_n)
        cq_push |-> drvhd_r[`ATFD_DH_UNIT] == socket_drive)
        else $error("command accepted for other unit");
    chk_ide_both: assert property (@(posedge clk) disable iff (!rst_n)
        mode == atfd_pkg::ATFD_MODE_IDE && wide |-> !acc)
        else $error("ide access with both enables decoded");
    chk_idle_hiz: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && host_ce1_n && host_ce2_n |=> host_data_oe == 2'h0)
        else $error("bus driven with no enable");
    chk_ide_lane: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && mode == atfd_pkg::ATFD_MODE_IDE && rd_s
        && sel == atfd_pkg::ATFD_SEL_CTL |=> host_data_oe == 2'h1)
        else $error("ide control read on wrong lane");
    chk_pri_map: assert property (@(posedge clk) disable iff (!rst_n)
        mode == atfd_pkg::ATFD_MODE_PRI && !host_reg_n && !host_ce1_n
        && host_addr[9:0] == 10'h1f5 |-> off == `ATFD_OFF_CYLHI)
        else $error("primary cylinder high misdecoded");
    chk_err_zero: assert property (@(posedge clk) disable iff (!rst_n)
        off == `ATFD_OFF_ERR |-> (rbyte & `ATFD_ERR_ZERO) == 8'h00)
        else $error("error reserved bits not zero");
    chk_feat_wr: assert property (@(posedge clk) disable iff (!rst_n)
        wreg && off == `ATFD_OFF_ERR && !core_done |=> feature_r == $past(wbyte))
        else $error("feature write lost");
endmodule

/* File: pkg/atfd_params.svh */
`ifndef ATFD_PARAMS_SVH
`define ATFD_PARAMS_SVH
// task-file offsets (low address bits)
`define ATFD_OFF_DATA      4'h0
`define ATFD_OFF_ERR      4'h1
`define ATFD_OFF_COUNT    4'h2
`define ATFD_OFF_SECT     4'h3
`define ATFD_OFF_CYLLO    4'h4
`define ATFD_OFF_CYLHI    4'h5
`define ATFD_OFF_DRVHD    4'h6
`define ATFD_OFF_STAT     4'h7
`define ATFD_OFF_DUPE     4'h8
`define ATFD_OFF_DUPO     4'h9
`define ATFD_OFF_DUPERR   4'hd
`define ATFD_OFF_ALTST    4'he
`define ATFD_OFF_DRVADR   4'hf
// full i/o bases
`define ATFD_PRI_CMD      10'h1f0
`define ATFD_PRI_CTL      10'h3f6
`define ATFD_SEC_CMD      10'h170
`define ATFD_SEC_CTL      10'h376
// field positions
`define ATFD_DH_LBA       6
`define ATFD_DH_UNIT      4
`define ATFD_DC_SOFT_RESET_BIT      2
`define ATFD_DC_IMASK     1
`define ATFD_ERR_ZERO     8'h2a
`define ATFD_DH_ONES      8'ha0
// reset values
`define ATFD_DH_RST       8'ha0
`define ATFD_COUNT_RST    8'h01
`endif

/* File: pkg/atfd_pkg.sv */
package atfd_pkg;
    typedef enum logic [4:0] {
        ATFD_MODE_MEM  = 5'h01,
        ATFD_MODE_IO16 = 5'h02,
        ATFD_MODE_PRI  = 5'h04,
        ATFD_MODE_SEC  = 5'h08,
        ATFD_MODE_IDE  = 5'h10
    } atfd_mode_t;
    typedef enum logic [4:0] {
        ATFD_SEL_NONE = 5'h01,
        ATFD_SEL_DATA = 5'h02,
        ATFD_SEL_REG  = 5'h04,
        ATFD_SEL_CTL  = 5'h08,
        ATFD_SEL_ADR  = 5'h10
    } atfd_sel_t;
endpackage

/* File: test/atfd_core_model.sv */
`timescale 1ns/10ps
module atfd_core_model #(
    parameter int AW = 9
) (
    // core side of the task file
    input  wire logic          clk,
    input  wire logic          stall,
    input  wire logic [AW-1:0] ptr,
    input  wire logic          wr,
    input  wire logic [15:0]   wdata,
    input  wire logic          wide,
    output logic      [15:0]   rdata,
    output logic               cmd_ready
);
    logic [7:0] mem [0:(1<<AW)-1];
    // preload byte = address so every read is predictable
    initial for (int i = 0; i < (1<<AW); i++) mem[i] = i[7:0];
    assign rdata = {mem[ptr+AW'(1)], mem[ptr]};
    // a stalled core refuses commands, as a busy sequencer would
    assign cmd_ready = ~stall;
    always @(posedge clk) begin
        if (wr) begin
            mem[ptr] <= wdata[7:0];
            if (wide) mem[ptr+AW'(1)] <= wdata[15:8];
        end
    end
endmodule

/* File: test/ata_task_file_decode_bench.sv */
`timescale 1ns/10ps
module ata_task_file_decode_bench;
    logic clk = 1'b0, rst_n = 1'b0, oe_n = 1'b1, we_n = 1'b1, iord_n = 1'b1, iowr_n = 1'b1;
    logic ce1_n = 1'b1, ce2_n = 1'b1, reg_n = 1'b1, sock = 1'b0, stall = 1'b1;
    logic irq_set = 1'b0, done = 1'b0, cen = 1'b1;
    atfd_pkg::atfd_mode_t mode = atfd_pkg::ATFD_MODE_MEM;
    logic [10:0] addr = 11'h000;
    logic [15:0] din = 16'h0000, dout, rdat, wdat, rd;
    logic [7:0]  st = 8'h50, er = 8'hff, ccode, feat, cnt, sect, cyllo, cylhi, drvhd;
    logic [1:0]  doe, ro;
    logic        irq_n, cvalid, cready, sreset, bwr, bwide;
    logic [8:0]  ptr;
    int          err_count = 0, n_tests = 0;
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    atfd_task_file DUT (.clk(clk), .rst_n(rst_n), .clk_en(cen), .mode(mode),
        .socket_drive(sock), .host_addr(addr), .host_ce1_n(ce1_n), .host_ce2_n(ce2_n),
        .host_reg_n(reg_n), .host_oe_n(oe_n), .host_we_n(we_n), .host_iord_n(iord_n),
        .host_iowr_n(iowr_n), .host_data_in(din), .host_data_out(dout), .host_data_oe(doe),
        .host_irq_n(irq_n), .core_status(st), .core_error(er), .core_irq_set(irq_set),
        .core_done(done), .core_count(8'h00), .core_sect(8'h99), .core_cyllo(8'h12),
        .core_cylhi(8'h34), .core_head(4'h5), .cmd_code(ccode), .cmd_valid(cvalid),
        .cmd_ready(cready), .soft_reset(sreset), .feature_r(feat), .count_r(cnt),
        .sect_r(sect), .cyllo_r(cyllo), .cylhi_r(cylhi), .drvhd_r(drvhd), .buf_ptr_r(ptr),
        .buf_wr(bwr), .buf_wdata(wdat), .buf_wide(bwide), .buf_rdata(rdat));
    atfd_core_model core (.clk(clk), .stall(stall), .ptr(ptr), .wr(bwr), .wdata(wdat),
        .wide(bwide), .rdata(rdat), .cmd_ready(cready));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one host cycle; ce is {ce2_n, ce1_n}; strobe low for four edges
    task automatic acc(input logic wr, input logic [10:0] a, input logic [1:0] ce,
                       input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        {ce2_n, ce1_n} <= ce;
        din <= d;
        reg_n <= (mode == atfd_pkg::ATFD_MODE_MEM);
        if (mode == atfd_pkg::ATFD_MODE_MEM) {oe_n, we_n} <= {wr, ~wr};
        else {iord_n, iowr_n} <= {wr, ~wr};
        repeat (3) @(posedge clk);
        #1 rd = dout;
        ro = doe;
        @(posedge clk);
        {oe_n, we_n, iord_n, iowr_n, ce2_n, ce1_n} <= 6'h3f;
        repeat (2) @(posedge clk);
    endtask
    task automatic row(input atfd_pkg::atfd_mode_t m, input logic [10:0] a,
                       input logic [1:0] ce, input logic [1:0] oe);
        @(posedge clk) mode <= m;
        acc(0, a, ce, 16'h0000);
        chk(ro, oe);
        if (oe != 2'b00) chk(rd[7:0], st);
    endtask
    task automatic wrap_up;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        acc(0, 11'h006, 2'b10, 0); chk(rd[7:0], 8'ha0);
        acc(0, 11'h002, 2'b10, 0); chk(rd[7:0], 8'h01);
        for (int i = 2; i < 6; i++) acc(1, 11'(i), 2'b10, 16'(8'h30 + i));
        for (int i = 2; i < 6; i++) begin
            acc(0, 11'(i), 2'b10, 0); chk(rd[7:0], 16'(8'h30 + i));
        end
        acc(1, 11'h006, 2'b10, 16'h000f);
        acc(0, 11'h006, 2'b10, 0); chk(rd[7:0], 8'haf);
        acc(1, 11'h001, 2'b10, 16'h0077); chk(feat, 8'h77);
        acc(0, 11'h001, 2'b10, 0); chk(rd[7:0], 8'hd5);
        acc(0, 11'h00d, 2'b10, 0); chk(rd[7:0], 8'hd5);
        acc(0, 11'h003, 2'b01, 0); chk({ro, rd[15:8]}, {2'b10, 8'h33});
        // a write made while the clock enable is low must not land
        @(posedge clk) cen <= 1'b0;
        acc(1, 11'h002, 2'b10, 16'h00aa);
        @(posedge clk) cen <= 1'b1;
        acc(0, 11'h002, 2'b10, 0); chk(rd[7:0], 8'h32);
    endtask
    task automatic t_data;
        acc(0, 11'h400, 2'b00, 0); chk({ro, rd}, {2'b11, 16'h0100});
        chk(ptr, 9'h002);
        acc(0, 11'h7fe, 2'b10, 0); chk(rd[7:0], 8'h02);
        chk(ptr, 9'h003);
        acc(1, 11'h000, 2'b00, 16'hbeef); chk(ptr, 9'h005);
    endtask
    task automatic t_io;
        row(atfd_pkg::ATFD_MODE_PRI, 11'h1f7, 2'b10, 2'b01);
        row(atfd_pkg::ATFD_MODE_PRI, 11'h3f6, 2'b10, 2'b01);
        row(atfd_pkg::ATFD_MODE_PRI, 11'h1f8, 2'b10, 2'b00);
        row(atfd_pkg::ATFD_MODE_SEC, 11'h177, 2'b10, 2'b01);
        row(atfd_pkg::ATFD_MODE_SEC, 11'h376, 2'b10, 2'b01);
        row(atfd_pkg::ATFD_MODE_SEC, 11'h1f7, 2'b10, 2'b00);
        row(atfd_pkg::ATFD_MODE_IO16, 11'h3f7, 2'b10, 2'b01);
        row(atfd_pkg::ATFD_MODE_IO16, 11'h2ae, 2'b10, 2'b01);
        row(atfd_pkg::ATFD_MODE_IDE, 11'h007, 2'b10, 2'b01);
        row(atfd_pkg::ATFD_MODE_IDE, 11'h007, 2'b00, 2'b00);
        row(atfd_pkg::ATFD_MODE_IDE, 11'h006, 2'b01, 2'b01);
        row(atfd_pkg::ATFD_MODE_IDE, 11'h005, 2'b01, 2'b00);
        row(atfd_pkg::ATFD_MODE_IDE, 11'h006, 2'b11, 2'b00);
    endtask
    task automatic t_cmd;
        @(posedge clk) mode <= atfd_pkg::ATFD_MODE_PRI;
        acc(1, 11'h1f5, 2'b10, 16'h0056);
        acc(0, 11'h1f5, 2'b10, 0); chk(rd[7:0], 8'h56);
        acc(1, 11'h1f6, 2'b10, 16'h0000);
        acc(1, 11'h1f7, 2'b10, 16'h00ec); chk({cvalid, ccode}, 9'h1ec);
        acc(1, 11'h1f6, 2'b10, 16'h0010);
        acc(1, 11'h1f7, 2'b10, 16'h0020);
        // release the stall for one pop: a second queued command would still show
        @(posedge clk) stall <= 1'b0;
        @(posedge clk) #1;
        chk(cvalid, 1'b0);
    endtask
    task automatic t_done;
        @(posedge clk) done <= 1'b1;
        @(posedge clk) done <= 1'b0;
        @(posedge clk) #1;
        chk({cnt, sect}, 16'h0099);
        chk({cyllo, cylhi}, 16'h1234);
        chk({8'h00, drvhd}, 16'h00b5);
    endtask
    task automatic t_irq;
        acc(1, 11'h3f6, 2'b10, 16'h0004); chk(sreset, 1'b1);
        acc(1, 11'h3f6, 2'b10, 16'h0002); chk(sreset, 1'b0);
        @(posedge clk) irq_set <= 1'b1;
        @(posedge clk) irq_set <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(irq_n, 1'b1);
        acc(1, 11'h3f6, 2'b10, 16'h0000); chk(irq_n, 1'b0);
        acc(0, 11'h3f6, 2'b10, 0); chk(irq_n, 1'b0);
        acc(0, 11'h1f7, 2'b10, 0); chk(irq_n, 1'b1);
        acc(0, 11'h1f1, 2'b10, 0); chk(rd[7:0], 8'hd5);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_data;
        t_io;
        t_cmd;
        t_done;
        t_irq;
        wrap_up;
    end
    // about 46 accesses of 7 cycles; far more than that means a hang
    initial begin
        #200000;
        err_count++;
        wrap_up;
    end
endmodule
